//--- fec_rx_status_defines.svh
// Register map, field positions, reset values and widths for FEC receive status
`ifndef FEC_RX_STATUS_DEFINES_SVH
`define FEC_RX_STATUS_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FEC_LANES          4
`define FEC_SYMERR_W       3
`define FEC_FILL_W         14
`define FEC_ADDR_W         12
`define FEC_CNT_W          32

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL           12'h000
`define REG_LOCK_STATUS    12'h004
`define REG_INT_STATUS     12'h008
`define REG_INT_ENABLE     12'h00C
`define REG_INT_CLEAR      12'h010
`define REG_CORR_COUNT     12'h014
`define REG_UNCORR_COUNT   12'h018
`define REG_SYMERR_COUNT   12'h01C

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_FREEZE_BIT    0
`define CTRL_CLEAR_BIT     1
`define INT_LOCKLOST_LSB   0
`define INT_UNCORR_BIT     4
`define INT_SYMERR_BIT     5
`define INT_W              6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET         1'b0
`define INT_ENABLE_RESET   6'h00
`define COUNT_RESET        32'h0000_0000

`endif

//--- fec_rx_status_pkg.sv
// Types shared by the FEC receive status logic
`default_nettype none

package fec_rx_status_pkg;

  // Per-codeword decode result
  typedef struct packed {
    logic strobe;
    logic corrected;
    logic uncorrectable;
  } cw_result_t;

  // Per-lane reported status
  typedef struct packed {
    logic        locked;
    logic [2:0]  symErr;
    logic [13:0] fill;
  } lane_status_t;

endpackage
`default_nettype wire

//--- fec_lane_status.sv
// One receive lane: registered lock, symbol-error and fill reporting
`timescale 1ns/1ns
`default_nettype none
`include "fec_rx_status_defines.svh"

module fec_lane_status
  import fec_rx_status_pkg::*;
#(
  parameter bit LOCK_PRESENT = 1'b1,
  parameter bit ERR_PRESENT  = 1'b1
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // From decoder lane logic
  input  wire logic                     lockIn,
  input  wire logic [`FEC_SYMERR_W-1:0] symErrIn,
  input  wire logic [`FEC_FILL_W-1:0]   fillIn,
  // Reported status
  output var  lane_status_t             status,
  output logic                          lockLost
);

  lane_status_t next_status;
  logic         next_lockLost;

  always_comb begin
    next_status.locked = LOCK_PRESENT ? lockIn : 1'b0;
    next_status.fill   = LOCK_PRESENT ? fillIn : '0;
    next_status.symErr = ERR_PRESENT ? symErrIn : '0;
    // Falling edge of the reported lock
    next_lockLost      = status.locked & ~next_status.locked;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status   <= '0;
      lockLost <= 1'b0;
    end else begin
      status   <= next_status;
      lockLost <= next_lockLost;
    end
  end

endmodule
`default_nettype wire

//--- fec_rx_status_reporting.sv
// FEC decoder receive status outputs with APB statistics and interrupt registers
`timescale 1ns/1ns
`default_nettype none
`include "fec_rx_status_defines.svh"

module fec_rx_status_reporting
  import fec_rx_status_pkg::*;
#(
  parameter bit STD_FEC_OPTION = 1'b1,
  parameter bit BYPASS_OPTION  = 1'b0
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`FEC_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // From decoder datapath
  input  wire logic                     decodeDone,
  input  wire logic                     decodeCorrected,
  input  wire logic                     decodeFailed,
  input  wire logic [`FEC_LANES-1:0]    laneLockIn,
  input  wire logic [`FEC_SYMERR_W-1:0] laneSymErrIn [`FEC_LANES],
  input  wire logic [`FEC_FILL_W-1:0]   laneFillIn [`FEC_LANES],
  // Lane lock status
  output logic                          fec_lane0_marker_locked,
  output logic                          fec_lane1_marker_locked,
  output logic                          fec_lane2_marker_locked,
  output logic                          fec_lane3_marker_locked,
  // Codeword results
  output logic                          codeword_corrected_pulse,
  output logic                          codeword_uncorrectable_pulse,
  output logic                          codeword_result_strobe,
  // Symbol error increments
  output logic [`FEC_SYMERR_W-1:0]      lane0_symbol_error_incr,
  output logic [`FEC_SYMERR_W-1:0]      lane1_symbol_error_incr,
  output logic [`FEC_SYMERR_W-1:0]      lane2_symbol_error_incr,
  output logic [`FEC_SYMERR_W-1:0]      lane3_symbol_error_incr,
  // Lane deskew fill
  output logic [`FEC_FILL_W-1:0]        laneFill0,
  output logic [`FEC_FILL_W-1:0]        laneFill1,
  output logic [`FEC_FILL_W-1:0]        laneFill2,
  output logic [`FEC_FILL_W-1:0]        laneFill3,
  // Interrupt
  output logic                          irq
);

  localparam bit CW_PRESENT = STD_FEC_OPTION | BYPASS_OPTION;

  // ----------------------------------------
  // Lane status
  // ----------------------------------------
  lane_status_t        lane [`FEC_LANES];
  logic [`FEC_LANES-1:0] laneLockLost;
  logic [`FEC_LANES-1:0] laneLocked;
  logic [`FEC_LANES-1:0] laneErrSeen;

  for (genvar i = 0; i < `FEC_LANES; i++) begin : g_lane
    fec_lane_status #(
      .LOCK_PRESENT (STD_FEC_OPTION),
      .ERR_PRESENT  ((i == 0) ? CW_PRESENT : STD_FEC_OPTION)
    ) u_lane (
      .clk      (clk),
      .resetn   (resetn),
      .lockIn   (laneLockIn[i]),
      .symErrIn (laneSymErrIn[i]),
      .fillIn   (laneFillIn[i]),
      .status   (lane[i]),
      .lockLost (laneLockLost[i])
    );
    assign laneLocked[i]  = lane[i].locked;
    assign laneErrSeen[i] = |lane[i].symErr;
  end

  assign fec_lane0_marker_locked = lane[0].locked;
  assign fec_lane1_marker_locked = lane[1].locked;
  assign fec_lane2_marker_locked = lane[2].locked;
  assign fec_lane3_marker_locked = lane[3].locked;
  assign lane0_symbol_error_incr = lane[0].symErr;
  assign lane1_symbol_error_incr = lane[1].symErr;
  assign lane2_symbol_error_incr = lane[2].symErr;
  assign lane3_symbol_error_incr = lane[3].symErr;
  assign laneFill0               = lane[0].fill;
  assign laneFill1               = lane[1].fill;
  assign laneFill2               = lane[2].fill;
  assign laneFill3               = lane[3].fill;

  // ----------------------------------------
  // Codeword result
  // ----------------------------------------
  cw_result_t cw;
  cw_result_t next_cw;

  always_comb begin
    next_cw.strobe        = CW_PRESENT & decodeDone;
    // Failure wins if the decoder flags both
    next_cw.uncorrectable = next_cw.strobe & decodeFailed;
    next_cw.corrected     = next_cw.strobe & decodeCorrected
                            & ~decodeFailed;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cw <= '0;
    end else begin
      cw <= next_cw;
    end
  end

  assign codeword_result_strobe       = cw.strobe;
  assign codeword_corrected_pulse     = cw.corrected;
  assign codeword_uncorrectable_pulse = cw.uncorrectable;

  // ----------------------------------------
  // Statistics counters and interrupt state
  // ----------------------------------------
  logic                 freeze;
  logic [`FEC_CNT_W-1:0] corrCount;
  logic [`FEC_CNT_W-1:0] uncorrCount;
  logic [`FEC_CNT_W-1:0] symErrCount;
  logic [`INT_W-1:0]    intStatus;
  logic [`INT_W-1:0]    intEnable;
  logic                 next_freeze;
  logic [`FEC_CNT_W-1:0] next_corrCount;
  logic [`FEC_CNT_W-1:0] next_uncorrCount;
  logic [`FEC_CNT_W-1:0] next_symErrCount;
  logic [`INT_W-1:0]    next_intStatus;
  logic [`INT_W-1:0]    next_intEnable;
  logic [`INT_W-1:0]    intEvents;
  logic [`FEC_CNT_W-1:0] symErrSum;
  logic                 wrAccess;
  logic                 countClear;

  assign wrAccess   = psel & penable & pwrite;
  assign countClear = wrAccess && paddr == `REG_CTRL && pwdata[`CTRL_CLEAR_BIT];
  assign intEvents  = {(|laneErrSeen), cw.uncorrectable, laneLockLost};

  always_comb begin
    symErrSum = '0;
    for (int i = 0; i < `FEC_LANES; i++) begin
      symErrSum = symErrSum + {{(`FEC_CNT_W-`FEC_SYMERR_W){1'b0}}, lane[i].symErr};
    end
  end

  always_comb begin
    next_freeze      = freeze;
    next_intEnable   = intEnable;
    next_corrCount   = corrCount;
    next_uncorrCount = uncorrCount;
    next_symErrCount = symErrCount;
    next_intStatus   = intStatus;
    if (wrAccess && paddr == `REG_CTRL) begin
      next_freeze = pwdata[`CTRL_FREEZE_BIT];
    end
    if (wrAccess && paddr == `REG_INT_ENABLE) begin
      next_intEnable = pwdata[`INT_W-1:0];
    end
    if (wrAccess && paddr == `REG_INT_CLEAR) begin
      next_intStatus = intStatus & ~pwdata[`INT_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_intStatus = next_intStatus | intEvents;
    if (countClear) begin
      next_corrCount   = `COUNT_RESET;
      next_uncorrCount = `COUNT_RESET;
      next_symErrCount = `COUNT_RESET;
    end else if (!freeze) begin
      next_corrCount   = corrCount + {{(`FEC_CNT_W-1){1'b0}}, cw.corrected};
      next_uncorrCount = uncorrCount + {{(`FEC_CNT_W-1){1'b0}}, cw.uncorrectable};
      next_symErrCount = symErrCount + symErrSum;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      freeze      <= `CTRL_RESET;
      intEnable   <= `INT_ENABLE_RESET;
      intStatus   <= '0;
      corrCount   <= `COUNT_RESET;
      uncorrCount <= `COUNT_RESET;
      symErrCount <= `COUNT_RESET;
    end else begin
      freeze      <= next_freeze;
      intEnable   <= next_intEnable;
      intStatus   <= next_intStatus;
      corrCount   <= next_corrCount;
      uncorrCount <= next_uncorrCount;
      symErrCount <= next_symErrCount;
    end
  end

  assign irq = |(intStatus & intEnable);

  // ----------------------------------------
  // APB read and response
  // ----------------------------------------
  logic [31:0] next_prdata;
  logic        addrOk;

  always_comb begin
    addrOk      = 1'b1;
    next_prdata = prdata;
    case (paddr)
      `REG_CTRL:         next_prdata = 32'(freeze);
      `REG_LOCK_STATUS:  next_prdata = 32'(laneLocked);
      `REG_INT_STATUS:   next_prdata = 32'(intStatus);
      `REG_INT_ENABLE:   next_prdata = 32'(intEnable);
      `REG_INT_CLEAR:    next_prdata = 32'h0000_0000;
      `REG_CORR_COUNT:   next_prdata = corrCount;
      `REG_UNCORR_COUNT: next_prdata = uncorrCount;
      `REG_SYMERR_COUNT: next_prdata = symErrCount;
      default: begin
        addrOk      = 1'b0;
        next_prdata = 32'h0000_0000;
      end
    endcase
    if (!(psel && !penable && !pwrite)) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrOk;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_corr_pulse: assert property (decodeDone && decodeCorrected && !decodeFailed
    && CW_PRESENT |=> codeword_corrected_pulse && codeword_result_strobe)
    else $error("corrected pulse missing");
  chk_uncorr_pulse: assert property (decodeDone && decodeFailed && CW_PRESENT
    |=> codeword_uncorrectable_pulse && codeword_result_strobe)
    else $error("uncorrectable pulse missing");
  chk_strobe_cause: assert property ($past(resetn)
    |-> codeword_result_strobe == (CW_PRESENT && $past(decodeDone)))
    else $error("strobe without codeword");
  chk_result_excl: assert property (!codeword_corrected_pulse
    || !codeword_uncorrectable_pulse)
    else $error("both results asserted");
  chk_result_strobed: assert property (codeword_corrected_pulse
    || codeword_uncorrectable_pulse |-> codeword_result_strobe)
    else $error("result outside strobe");
  chk_lock_follow: assert property (STD_FEC_OPTION && laneLockIn[2]
    |=> fec_lane2_marker_locked)
    else $error("lane lock not reported");
  chk_lock0_follow: assert property (STD_FEC_OPTION && $rose(laneLockIn[0])
    |=> fec_lane0_marker_locked)
    else $error("lane 0 lock not reported");
  chk_symerr_pass: assert property (STD_FEC_OPTION
    |=> lane3_symbol_error_incr == $past(laneSymErrIn[3]))
    else $error("symbol error count wrong");
  chk_fill_pass: assert property (STD_FEC_OPTION
    |=> laneFill1 == $past(laneFillIn[1]))
    else $error("lane fill wrong");
  chk_option_off: assert property (!STD_FEC_OPTION |-> !fec_lane3_marker_locked
    && laneFill2 == '0 && lane1_symbol_error_incr == '0)
    else $error("lane outputs active without option");
  chk_bypass_lane0: assert property (!CW_PRESENT |-> lane0_symbol_error_incr == '0
    && !codeword_result_strobe)
    else $error("codeword outputs active without option");
  chk_irq_level: assert property (cw.uncorrectable && intEnable[`INT_UNCORR_BIT]
    |=> irq || !intEnable[`INT_UNCORR_BIT])
    else $error("interrupt not raised");
  chk_lock_lost_set: assert property (laneLockLost[0] |=> intStatus[`INT_LOCKLOST_LSB])
    else $error("lock loss not recorded");
  chk_count_clear: assert property (countClear |=> corrCount == `COUNT_RESET)
    else $error("counter clear ignored");
  chk_freeze_hold: assert property (freeze && !countClear |=> corrCount == $past(corrCount))
    else $error("counter moved while frozen");

  cov_corrected: cover property (codeword_corrected_pulse ##1 codeword_corrected_pulse);
  cov_uncorrect: cover property (codeword_uncorrectable_pulse);
  cov_lock_lost: cover property ($fell(fec_lane1_marker_locked));
  cov_irq:       cover property ($rose(irq));
  cov_frozen:    cover property (freeze && codeword_corrected_pulse);

endmodule
`default_nettype wire

//--- fec_stat_counters.sv
// Statistics counters fed by the FEC receive status outputs
`timescale 1ns/1ns
`default_nettype none

module fec_stat_counters (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Increments from the status block
  input  wire logic       corrPulse,
  input  wire logic       uncPulse,
  input  wire logic [2:0] symErr [4],
  // Accumulated totals
  output logic [31:0]     corrCount,
  output logic [31:0]     uncCount,
  output logic [31:0]     symCount
);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      corrCount <= 32'h0000_0000;
      uncCount  <= 32'h0000_0000;
      symCount  <= 32'h0000_0000;
    end else begin
      corrCount <= corrCount + 32'(corrPulse);
      uncCount  <= uncCount + 32'(uncPulse);
      symCount  <= symCount + 32'(symErr[0]) + 32'(symErr[1]) + 32'(symErr[2])
                   + 32'(symErr[3]);
    end
  end
endmodule

`default_nettype wire

//--- tb_fec_rx_status_reporting.sv
// Self-checking bench for the FEC receive status block
`timescale 1ns/1ns
`default_nettype none
`include "fec_rx_status_defines.svh"

module tb_fec_rx_status_reporting;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        decodeDone = 0, decodeCorrected = 0, decodeFailed = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, corrCount, uncCount, symCount;
  logic        pready, pslverr, irq, lk0, lk1, lk2, lk3, cPulse, uPulse, strobe;
  logic [3:0]  laneLockIn = 0, lockHold = 0, lastLock = 0, pLock = 0;
  logic [2:0]  laneSymErrIn [4] = '{default: 0};
  logic [13:0] laneFillIn [4] = '{default: 0};
  logic [2:0]  se [4];
  logic [13:0] f0, f1, f2, f3;
  logic        pDone = 0, pCorr = 0, pFail = 0, traffic = 0;
  logic [11:0] pSym = 0;
  logic [55:0] pFill = 0;
  int          seed = 22, num_errors = 0, samples_checked = 0;
  int          expCorr = 0, expUnc = 0, expSym = 0, expStat = 0;
  wire         bStb [2], bCor [2], bUnc [2];
  wire  [3:0]  bLk [2];
  wire  [11:0] bSe [2];
  wire  [55:0] bFl [2];
  logic [5:0]  expCw;

  always #4 clk = ~clk;

  fec_rx_status_reporting i_fec_rx_status_reporting (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .decodeDone(decodeDone), .decodeCorrected(decodeCorrected), .decodeFailed(decodeFailed),
    .laneLockIn(laneLockIn), .laneSymErrIn(laneSymErrIn), .laneFillIn(laneFillIn),
    .fec_lane0_marker_locked(lk0), .fec_lane1_marker_locked(lk1),
    .fec_lane2_marker_locked(lk2), .fec_lane3_marker_locked(lk3),
    .codeword_corrected_pulse(cPulse), .codeword_uncorrectable_pulse(uPulse),
    .codeword_result_strobe(strobe),
    .lane0_symbol_error_incr(se[0]), .lane1_symbol_error_incr(se[1]),
    .lane2_symbol_error_incr(se[2]), .lane3_symbol_error_incr(se[3]),
    .laneFill0(f0), .laneFill1(f1), .laneFill2(f2), .laneFill3(f3), .irq(irq));

  fec_stat_counters i_fec_stat_counters (
    .clk(clk), .resetn(resetn), .corrPulse(cPulse), .uncPulse(uPulse), .symErr(se),
    .corrCount(corrCount), .uncCount(uncCount), .symCount(symCount));

  // Standard option off; codeword outputs kept only in the first copy
  for (genvar k = 0; k < 2; k++) begin : g_opt
    fec_rx_status_reporting #(
      .STD_FEC_OPTION (1'b0),
      .BYPASS_OPTION  (k == 0)
    ) i_fec_rx_status_reporting (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .decodeDone(decodeDone), .decodeCorrected(decodeCorrected), .decodeFailed(decodeFailed),
      .laneLockIn(laneLockIn), .laneSymErrIn(laneSymErrIn), .laneFillIn(laneFillIn),
      .fec_lane0_marker_locked(bLk[k][0]), .fec_lane1_marker_locked(bLk[k][1]),
      .fec_lane2_marker_locked(bLk[k][2]), .fec_lane3_marker_locked(bLk[k][3]),
      .codeword_corrected_pulse(bCor[k]), .codeword_uncorrectable_pulse(bUnc[k]),
      .codeword_result_strobe(bStb[k]),
      .lane0_symbol_error_incr(bSe[k][2:0]), .lane1_symbol_error_incr(bSe[k][5:3]),
      .lane2_symbol_error_incr(bSe[k][8:6]), .lane3_symbol_error_incr(bSe[k][11:9]),
      .laneFill0(bFl[k][13:0]), .laneFill1(bFl[k][27:14]), .laneFill2(bFl[k][41:28]),
      .laneFill3(bFl[k][55:42]), .irq());
  end

  task automatic finish_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // Decoder stimulus, last applied values kept
  // ----------------------------------------
  always @(posedge clk) begin
    pDone = decodeDone;
    pCorr = decodeCorrected;
    pFail = decodeFailed;
    pLock = laneLockIn;
    pSym  = {laneSymErrIn[3], laneSymErrIn[2], laneSymErrIn[1], laneSymErrIn[0]};
    pFill = {laneFillIn[3], laneFillIn[2], laneFillIn[1], laneFillIn[0]};
    decodeDone      <= traffic & 1'($random(seed));
    decodeCorrected <= traffic & 1'($random(seed));
    decodeFailed    <= traffic & 1'($random(seed));
    laneLockIn      <= traffic ? 4'($random(seed)) : lockHold;
    for (int i = 0; i < 4; i++) begin
      laneSymErrIn[i] <= traffic ? 3'($random(seed)) : 3'h0;
      laneFillIn[i]   <= traffic ? 14'($random(seed)) : 14'h0000;
    end
  end

  // ----------------------------------------
  // Output compare and reference model
  // ----------------------------------------
  always @(negedge clk) begin
    if (resetn) begin
      check(64'(strobe), 64'(pDone));
      check(64'(cPulse), 64'(pDone & pCorr & !pFail));
      check(64'(uPulse), 64'(pDone & pFail));
      check(64'(cPulse & uPulse), 64'h0);
      check(64'({lk1, lk0}), 64'(pLock[1:0]));
      check(64'({lk3, lk2}), 64'(pLock[3:2]));
      check(64'({se[3], se[2], se[1], se[0]}), 64'(pSym));
      check(64'({f3, f2, f1, f0}), 64'(pFill));
      expCw = {pDone, pDone & pCorr & !pFail, pDone & pFail, pSym[2:0]};
      for (int k = 0; k < 2; k++) begin
        check(64'({bStb[k], bCor[k], bUnc[k], bSe[k][2:0]}), k ? 64'h0 : 64'(expCw));
        check(64'({bLk[k], bSe[k][11:3]}), 64'h0);
        check(64'(bFl[k]), 64'h0);
      end
      expCorr += int'(pDone & pCorr & !pFail);
      expUnc  += int'(pDone & pFail);
      expSym  += pSym[2:0] + pSym[5:3] + pSym[8:6] + pSym[11:9];
      expStat |= int'(lastLock & ~pLock);
      if (pDone & pFail)
        expStat |= 16;
      if (pSym != 0)
        expStat |= 32;
      lastLock = pLock;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic        err;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `REG_INT_ENABLE, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    apb(1'b0, `REG_CORR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    apb(1'b0, 12'h020, 32'h0000_0000, rd, err);
    check(64'({err, rd}), 64'h1_0000_0000);
    apb(1'b1, `REG_INT_ENABLE, 32'h0000_003f, rd, err);
    traffic <= 1'b1;
    repeat (400) @(posedge clk);
    traffic  <= 1'b0;
    lockHold <= 4'h5;
    repeat (4) @(posedge clk);
    apb(1'b0, `REG_LOCK_STATUS, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h5);
    apb(1'b0, `REG_CORR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'(expCorr));
    apb(1'b0, `REG_UNCORR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'(expUnc));
    apb(1'b0, `REG_SYMERR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'(expSym));
    check(64'({corrCount, uncCount}), {32'(expCorr), 32'(expUnc)});
    check(64'(symCount), 64'(expSym));
    apb(1'b0, `REG_INT_STATUS, 32'h0000_0000, rd, err);
    check(64'(rd), 64'(expStat));
    #1 check(64'(irq), 64'(expStat != 0));
    apb(1'b1, `REG_INT_ENABLE, 32'h0000_0000, rd, err);
    repeat (2) @(posedge clk);
    #1 check(64'(irq), 64'h0);
    apb(1'b1, `REG_INT_CLEAR, 32'h0000_003f, rd, err);
    expStat = 0;
    apb(1'b0, `REG_INT_STATUS, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    apb(1'b1, `REG_CTRL, 32'h0000_0002, rd, err);
    apb(1'b0, `REG_CORR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    // Frozen counters must not move under traffic
    apb(1'b1, `REG_CTRL, 32'h0000_0001, rd, err);
    traffic <= 1'b1;
    repeat (40) @(posedge clk);
    traffic  <= 1'b0;
    lockHold <= 4'h0;
    repeat (4) @(posedge clk);
    apb(1'b0, `REG_CTRL, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h1);
    apb(1'b0, `REG_CORR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    apb(1'b0, `REG_SYMERR_COUNT, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    // Mid-run reset clears control and sticky state
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    apb(1'b0, `REG_INT_STATUS, 32'h0000_0000, rd, err);
    check(64'(rd), 64'h0);
    finish_test();
  end
endmodule

`default_nettype wire
